// *** logic/baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module baud_gen
  import sio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // Rate control
  baud_if.gen bif
);
  logic [4:0] pre_reg, pre_next;
  logic [7:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  logic [4:0] mask;
  logic src_tick;

  always_comb begin
    case (bif.count_source)
      2'h0: mask = PRE_F1;
      2'h1: mask = PRE_F8;
      2'h2: mask = PRE_F32;
      default: mask = PRE_F2;
    endcase
    src_tick = (pre_reg & mask) == mask;
    pre_next = pre_reg + 5'h01;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!bif.run) begin
      cnt_next = bif.divider;
    end else if (src_tick) begin
      // Half period of n+1 source ticks gives source / 2(n+1)
      if (cnt_reg == RST_BYTE) begin
        cnt_next = bif.divider;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= 5'h00;
      cnt_reg <= RST_BYTE;
      tick_reg <= 1'b0;
    end else if (ce) begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign bif.tick = tick_reg;
endmodule // baud_gen
`default_nettype wire

// *** logic/baud_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
  logic [1:0] count_source;
  logic [7:0] divider;
  logic run;
  logic tick;
  modport gen (input count_source, input divider, input run, output tick);
  modport user (output count_source, output divider, output run, input tick);
endinterface
`default_nettype wire

// *** logic/sio_pkg.sv ***
package sio_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFS_TX_BUF = 4'h0;
  localparam logic [3:0] OFS_RX_BUF = 4'h1;
  localparam logic [3:0] OFS_BAUD = 4'h2;
  localparam logic [3:0] OFS_MODE = 4'h3;
  localparam logic [3:0] OFS_CTRL0 = 4'h4;
  localparam logic [3:0] OFS_CTRL1 = 4'h5;
  localparam logic [3:0] OFS_SMR1 = 4'h6;
  localparam logic [3:0] OFS_SMR2 = 4'h7;
  localparam logic [3:0] OFS_SMR3 = 4'h8;
  localparam logic [3:0] OFS_SMR4 = 4'h9;
  localparam logic [3:0] OFS_SHARED = 4'hA;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MODE_CLOCK_DIRECTION_BIT = 3;
  localparam int MODE_DATA_IO_POLARITY_BIT = 7;
  localparam logic [2:0] MODE_CLK_SYNC = 3'h1;
  localparam int C0_HS_SEL = 2;
  localparam int C0_SHIFT_EMPTY = 3;
  localparam int C0_HS_DIS = 4;
  localparam int C0_OPEN_DRAIN = 5;
  localparam int C0_CLOCK_POLARITY_BIT = 6;
  localparam int C0_MSB_FIRST = 7;
  localparam int C1_TE = 0;
  localparam int C1_TBE = 1;
  localparam int C1_RE = 2;
  localparam int C1_RC = 3;
  localparam int C1_IRS = 4;
  localparam int C1_RRM = 5;
  localparam int C1_INVERT = 6;
  localparam int SH_IRS0 = 0;
  localparam int SH_RRM0 = 2;
  localparam int SH_CLK_CHOICE = 4;
  localparam int SH_MULTI_CLK = 5;
  localparam int SH_SEP_HS = 6;
  localparam int RB_OVERRUN = 12;
  // Writable masks; status bits are read-only
  localparam logic [7:0] C0_WR_MASK = 8'hF7;
  localparam logic [7:0] C1_WR_MASK = 8'hF5;
  localparam logic [7:0] SH_WR_MASK = 8'h7F;
  // ---------------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] C1_RST = 8'h02;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] OVERRUN_BIT = 4'h7;
  // Prescaler masks for count sources 0..3: /1, /8, /32, /2
  localparam logic [4:0] PRE_F1 = 5'h00;
  localparam logic [4:0] PRE_F8 = 5'h07;
  localparam logic [4:0] PRE_F32 = 5'h1F;
  localparam logic [4:0] PRE_F2 = 5'h01;

  typedef enum logic {ST_IDLE, ST_XFER} xfer_state_t;
endpackage

// *** logic/sync_serial_channel.sv ***
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_channel
  import sio_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Serial data pins
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_n,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_in_used,
  // Transfer clock pins
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe_n,
  output logic alternate_clock_pin_o,
  output logic alternate_clock_pin_oe_n,
  // Handshake pins
  input wire logic handshake_pin_i,
  output logic handshake_pin_o,
  output logic handshake_pin_oe_n,
  input wire logic shared_alternate_pin_i,
  // Events
  output logic tx_event,
  output logic rx_event
);
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] tbuf_reg, tbuf_next, baud_reg, baud_next, mode_reg, mode_next;
  logic [7:0] c0_reg, c0_next, c1_reg, c1_next, sh_reg, sh_next;
  logic [7:0] smr1_reg, smr1_next, smr2_reg, smr2_next, smr3_reg, smr3_next, smr4_reg, smr4_next;
  logic [7:0] rbuf_reg, rbuf_next;
  logic ovr_reg, ovr_next;
  logic [15:0] rdata_reg, rdata_next;
  // ---------------------------------------------------------------------------
  // Transfer engine state
  // ---------------------------------------------------------------------------
  xfer_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bits_reg, bits_next;
  logic sclk_reg, sclk_next;
  logic ext_prev_reg, ext_prev_next;
  logic dout_reg, dout_next;
  logic txev_reg, txev_next, rxev_reg, rxev_next;
  logic [3:0] s1_reg, s2_reg;
  logic cko_reg, cko_next, ckoe_reg, ckoe_next;
  logic alt_reg, alt_next, altoe_reg, altoe_next;
  logic hso_reg, hso_next, hsoe_reg, hsoe_next;
  logic doe_reg, doe_next, rxuse_reg, rxuse_next;

  baud_if bif ();
  baud_gen u_baud (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .bif(bif.gen)
  );

  function automatic logic [7:0] flip(input logic [7:0] d, input logic inv);
    flip = inv ? ~d : d;
  endfunction

  // Decoded controls
  logic serial_on, ext_clk, clock_polarity_bit, msb_first, invert, te, re, tbe, rc;
  logic open_drain, hs_dis, hs_sel, irs, rrm, multi_clk, clk_choice, sep_hs;
  logic ext_clk_s, rx_s, cts_s, shared_s, cts_in, cts_ok, idle_lvl;
  logic lead, trail, sample_bit, start_ok;
  logic [7:0] rx_byte;

  always_comb begin
    serial_on = mode_reg[2:0] == MODE_CLK_SYNC;
    ext_clk = mode_reg[MODE_CLOCK_DIRECTION_BIT];
    clock_polarity_bit = c0_reg[C0_CLOCK_POLARITY_BIT];
    msb_first = c0_reg[C0_MSB_FIRST];
    invert = c1_reg[C1_INVERT];
    te = c1_reg[C1_TE];
    re = c1_reg[C1_RE];
    tbe = c1_reg[C1_TBE];
    rc = c1_reg[C1_RC];
    hs_dis = c0_reg[C0_HS_DIS];
    hs_sel = c0_reg[C0_HS_SEL];
    // Channel 2 output is open-drain whatever the select bit says
    open_drain = c0_reg[C0_OPEN_DRAIN] || (CHANNEL == 2);
    irs = (CHANNEL == 2) ? c1_reg[C1_IRS] : sh_reg[SH_IRS0 + CHANNEL];
    rrm = (CHANNEL == 2) ? c1_reg[C1_RRM] : sh_reg[SH_RRM0 + CHANNEL];
    multi_clk = (CHANNEL == 1) && sh_reg[SH_MULTI_CLK];
    clk_choice = sh_reg[SH_CLK_CHOICE];
    sep_hs = (CHANNEL == 0) && sh_reg[SH_SEP_HS];
    ext_clk_s = s2_reg[0];
    rx_s = s2_reg[1];
    cts_s = s2_reg[2];
    shared_s = s2_reg[3];
    cts_in = sep_hs ? shared_s : cts_s;
    // CTS only gates when enabled and selected as input
    cts_ok = hs_dis || (hs_sel && !sep_hs) || !cts_in;
    idle_lvl = !clock_polarity_bit;
    // External clock must rest at its idle level before a frame starts
    start_ok = serial_on && te && !tbe && cts_ok && (!ext_clk || ext_clk_s == idle_lvl);
    if (ext_clk) begin
      lead = ext_prev_reg == idle_lvl && ext_clk_s != idle_lvl;
      trail = ext_prev_reg != idle_lvl && ext_clk_s == idle_lvl;
    end else begin
      lead = bif.tick && sclk_reg == idle_lvl;
      trail = bif.tick && sclk_reg != idle_lvl;
    end
    // Leaving idle drives, returning samples: polarity 0 drives on fall
    sample_bit = rx_s;
    rx_byte = msb_first ? {shift_reg[6:0], sample_bit} : {sample_bit, shift_reg[7:1]};
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    tbuf_next = tbuf_reg;
    baud_next = baud_reg;
    mode_next = mode_reg;
    c0_next = c0_reg;
    c1_next = c1_reg;
    sh_next = sh_reg;
    smr1_next = smr1_reg;
    smr2_next = smr2_reg;
    smr3_next = smr3_reg;
    smr4_next = smr4_reg;
    rbuf_next = rbuf_reg;
    ovr_next = ovr_reg;
    state_next = state_reg;
    shift_next = shift_reg;
    bits_next = bits_reg;
    sclk_next = sclk_reg;
    ext_prev_next = ext_clk_s;
    dout_next = dout_reg;
    txev_next = 1'b0;
    rxev_next = 1'b0;
    rdata_next = 16'h0000;

    // Software side first so hardware set/clear below takes priority
    if (wr) begin
      case (addr)
        OFS_TX_BUF: begin
          tbuf_next = wdata;
          c1_next[C1_TBE] = 1'b0;
        end
        OFS_BAUD: baud_next = wdata;
        OFS_MODE: mode_next = wdata;
        OFS_CTRL0: c0_next = (wdata & C0_WR_MASK) | (c0_reg & ~C0_WR_MASK);
        OFS_CTRL1: c1_next = (wdata & C1_WR_MASK) | (c1_reg & ~C1_WR_MASK);
        OFS_SMR1: smr1_next = wdata;
        OFS_SMR2: smr2_next = wdata;
        OFS_SMR3: smr3_next = wdata;
        OFS_SMR4: smr4_next = wdata;
        OFS_SHARED: sh_next = wdata & SH_WR_MASK;
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        OFS_RX_BUF: begin
          // Overrun bit travels with the data it corrupted
          rdata_next = {3'h0, ovr_reg, 4'h0, rbuf_reg};
          c1_next[C1_RC] = 1'b0;
          ovr_next = 1'b0;
          if (rrm) begin
            c1_next[C1_TBE] = 1'b0;
          end
        end
        OFS_BAUD: rdata_next = {8'h00, baud_reg};
        OFS_MODE: rdata_next = {8'h00, mode_reg};
        OFS_CTRL0: rdata_next = {8'h00, c0_reg};
        OFS_CTRL1: rdata_next = {8'h00, c1_reg};
        OFS_SMR1: rdata_next = {8'h00, smr1_reg};
        OFS_SMR2: rdata_next = {8'h00, smr2_reg};
        OFS_SMR3: rdata_next = {8'h00, smr3_reg};
        OFS_SMR4: rdata_next = {8'h00, smr4_reg};
        OFS_SHARED: rdata_next = {8'h00, sh_reg};
        default: rdata_next = 16'h0000;
      endcase
    end

    if (!serial_on) begin
      dout_next = 1'b1;
      sclk_next = idle_lvl;
    end

    case (state_reg)
      ST_IDLE: begin
        sclk_next = idle_lvl;
        if (start_ok) begin
          // A frame needs TE set even to receive, and always loads and shifts whatever is buffered
          shift_next = flip(tbuf_next, invert);
          c1_next[C1_TBE] = 1'b1;
          c0_next[C0_SHIFT_EMPTY] = 1'b0;
          bits_next = 4'h0;
          state_next = ST_XFER;
          txev_next = !irs;
        end
      end
      ST_XFER: begin
        if (!ext_clk && bif.tick) begin
          sclk_next = !sclk_reg;
        end
        if (lead) begin
          dout_next = msb_first ? shift_reg[7] : shift_reg[0];
        end
        if (trail) begin
          shift_next = rx_byte;
          bits_next = bits_reg + 4'h1;
          if (re && bits_reg + 4'h1 == OVERRUN_BIT && rc) begin
            ovr_next = 1'b1;
          end
          if (bits_reg + 4'h1 == LAST_BIT) begin
            if (re) begin
              rbuf_next = flip(rx_byte, invert);
              c1_next[C1_RC] = 1'b1;
              rxev_next = 1'b1;
            end
            c0_next[C0_SHIFT_EMPTY] = 1'b1;
            txev_next = irs;
            state_next = ST_IDLE;
          end
        end
        if (!serial_on || !te) begin
          state_next = ST_IDLE;
          c0_next[C0_SHIFT_EMPTY] = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  always_comb begin
    // Open-drain never drives high, so the idle high becomes a float
    doe_next = !serial_on || (open_drain && dout_next);
    rxuse_next = serial_on && c1_next[C1_RE];
    cko_next = sclk_next;
    ckoe_next = !(serial_on && !ext_clk);
    alt_next = idle_lvl;
    altoe_next = 1'b1;
    if (multi_clk && serial_on && !ext_clk) begin
      altoe_next = 1'b0;
      if (clk_choice) begin
        alt_next = sclk_next;
        cko_next = idle_lvl;
      end else begin
        alt_next = idle_lvl;
      end
    end
    // Ready to receive while reception is on and the buffer is free
    hso_next = !(c1_next[C1_RE] && !c1_next[C1_RC]);
    hsoe_next = !(serial_on && !hs_dis && hs_sel);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tbuf_reg <= RST_BYTE;
      baud_reg <= RST_BYTE;
      mode_reg <= RST_BYTE;
      c0_reg <= RST_BYTE | (8'h01 << C0_SHIFT_EMPTY);
      c1_reg <= C1_RST;
      sh_reg <= RST_BYTE;
      smr1_reg <= RST_BYTE;
      smr2_reg <= RST_BYTE;
      smr3_reg <= RST_BYTE;
      smr4_reg <= RST_BYTE;
      rbuf_reg <= RST_BYTE;
      ovr_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      state_reg <= ST_IDLE;
      shift_reg <= RST_BYTE;
      bits_reg <= 4'h0;
      sclk_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
      dout_reg <= 1'b1;
      txev_reg <= 1'b0;
      rxev_reg <= 1'b0;
      s1_reg <= 4'hF;
      s2_reg <= 4'hF;
      cko_reg <= 1'b1;
      ckoe_reg <= 1'b1;
      alt_reg <= 1'b1;
      altoe_reg <= 1'b1;
      hso_reg <= 1'b1;
      hsoe_reg <= 1'b1;
      doe_reg <= 1'b1;
      rxuse_reg <= 1'b0;
    end else if (ce) begin
      tbuf_reg <= tbuf_next;
      baud_reg <= baud_next;
      mode_reg <= mode_next;
      c0_reg <= c0_next;
      c1_reg <= c1_next;
      sh_reg <= sh_next;
      smr1_reg <= smr1_next;
      smr2_reg <= smr2_next;
      smr3_reg <= smr3_next;
      smr4_reg <= smr4_next;
      rbuf_reg <= rbuf_next;
      ovr_reg <= ovr_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      sclk_reg <= sclk_next;
      ext_prev_reg <= ext_prev_next;
      dout_reg <= dout_next;
      txev_reg <= txev_next;
      rxev_reg <= rxev_next;
      s1_reg <= {shared_alternate_pin_i, handshake_pin_i, serial_data_in_pin_i, transfer_clock_pin_i};
      s2_reg <= s1_reg;
      cko_reg <= cko_next;
      ckoe_reg <= ckoe_next;
      alt_reg <= alt_next;
      altoe_reg <= altoe_next;
      hso_reg <= hso_next;
      hsoe_reg <= hsoe_next;
      doe_reg <= doe_next;
      rxuse_reg <= rxuse_next;
    end
  end

  assign bif.count_source = c0_reg[1:0];
  assign bif.divider = baud_reg;
  assign bif.run = state_reg == ST_XFER && !ext_clk;

  assign rdata = rdata_reg;
  assign serial_data_out_pin_o = dout_reg;
  assign serial_data_out_pin_oe_n = doe_reg;
  assign serial_data_in_used = rxuse_reg;
  assign transfer_clock_pin_o = cko_reg;
  assign transfer_clock_pin_oe_n = ckoe_reg;
  assign alternate_clock_pin_o = alt_reg;
  assign alternate_clock_pin_oe_n = altoe_reg;
  assign handshake_pin_o = hso_reg;
  assign handshake_pin_oe_n = hsoe_reg;
  assign tx_event = txev_reg;
  assign rx_event = rxev_reg;
endmodule // sync_serial_channel
`default_nettype wire

// *** verif/sync_serial_channel_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_channel_test
  import sio_pkg::*;
();
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cts_n = 1'b0;
  logic ext_ck = 1'b1;
  logic pol = 1'b0;
  logic pclr = 1'b0;
  logic [7:0] pbyte = 8'h00;
  logic [15:0] rdata;
  logic sdo, sdo_oe_n, sdi, din_used, ck_o, ck_oe_n, alt_o, alt_oe_n, hs_o, hs_oe_n, tx_event, rx_event;
  logic [7:0] got;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic rd_seen = 1'b0;
  logic ck_d = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int cyc = 0;
  int last_rise = 0;
  int per = 0;
  logic [7:0] c0_tab [4] = '{8'h10, 8'h51, 8'h92, 8'hD3};
  int pre [4] = '{1, 8, 32, 2};
  always #2.5 clock = ~clock;
  sync_serial_channel #(.CHANNEL(1)) u_sync_serial_channel (
    .clock(clock), .nrst(nrst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .serial_data_out_pin_o(sdo), .serial_data_out_pin_oe_n(sdo_oe_n), .serial_data_in_pin_i(sdi),
    .serial_data_in_used(din_used), .transfer_clock_pin_i(ext_ck), .transfer_clock_pin_o(ck_o),
    .transfer_clock_pin_oe_n(ck_oe_n), .alternate_clock_pin_o(alt_o), .alternate_clock_pin_oe_n(alt_oe_n),
    .handshake_pin_i(cts_n), .handshake_pin_o(hs_o), .handshake_pin_oe_n(hs_oe_n),
    .shared_alternate_pin_i(cts_n), .tx_event(tx_event), .rx_event(rx_event));
  sync_serial_partner u_sync_serial_partner (
    .sclk(ck_oe_n ? ext_ck : ck_o), .sdo(sdo), .sdi(sdi), .pol(pol), .clr(pclr), .tx_byte(pbyte), .rx_bits(got));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // The expectation is queued before the strobe so the monitor always finds it
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic wait_rx(input int n);
    int k = 0;
    while (rx_cnt < n && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (rx_cnt < n) begin
      bad_count++;
      $display("CHECK FAILED receive wait expected %0d seen %0d", n, rx_cnt);
      end_sim();
    end
  endtask
  task automatic arm(input logic p);
    pol <= p;
    pbyte <= 8'($urandom);
    pclr <= 1'b1;
    @(posedge clock);
    pclr <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      rev[k] = v[7 - k];
    end
  endfunction
  // ---------------------------------------------------------------------------
  // Monitor: read answers, events, clock period
  // ---------------------------------------------------------------------------
  always @(posedge clock) begin
    if (rd_seen) begin
      check("register read", exp_q.pop_front(), rdata & msk_q.pop_front());
    end
    rd_seen <= rd;
    rx_cnt <= rx_cnt + int'(rx_event === 1'b1);
    tx_cnt <= tx_cnt + int'(tx_event === 1'b1);
    cyc <= cyc + 1;
    ck_d <= ck_o;
    if (ck_o === 1'b1 && ck_d === 1'b0) begin
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] inv;
    void'($urandom(32'hCB571C89));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    rd_reg(OFS_CTRL1, {8'h00, C1_RST}, 16'hFFFF);
    rd_reg(OFS_CTRL0, 16'h0008, 16'hFFFF);
    wr_reg(OFS_CTRL1, 8'h00);
    rd_reg(OFS_CTRL1, 16'h0002, 16'hFFFF);
    rd_reg(4'hF, 16'h0000, 16'hFFFF);
    wr_reg(OFS_MODE, 8'h09);
    settle();
    check("clock pin enable", 16'h1, 16'(ck_oe_n));
    wr_reg(OFS_MODE, {5'h00, MODE_CLK_SYNC});
    wr_reg(OFS_CTRL0, 8'h30);
    settle();
    check("clock pin enable", 16'h0, 16'(ck_oe_n));
    check("open drain idle", 16'h1, 16'(sdo_oe_n));
    wr_reg(OFS_CTRL0, 8'h10);
    wr_reg(OFS_CTRL1, 8'h01);
    wr_reg(OFS_SHARED, 8'h20);
    settle();
    check("data out idle", 16'h1, {14'h0, sdo_oe_n, sdo});
    check("data input use", 16'h0, 16'(din_used));
    check("alternate clock", 16'h1, {14'h0, alt_oe_n, alt_o});
    wr_reg(OFS_SHARED, 8'h00);
    // Every count source, both polarities, both bit orders, invert on and off
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_BAUD, 8'(i + 3));
      rd_reg(OFS_BAUD, 16'(i + 3), 16'hFFFF);
      wr_reg(OFS_CTRL0, c0_tab[i]);
      rd_reg(OFS_CTRL0, {8'h00, c0_tab[i]}, 16'h00F7);
      inv = i[0] ? 8'hFF : 8'h00;
      wr_reg(OFS_CTRL1, 8'h05 | (inv & 8'h40));
      arm(c0_tab[i][C0_CLOCK_POLARITY_BIT]);
      d = 8'($urandom);
      wr_reg(OFS_TX_BUF, d);
      wait_rx(rx_cnt + 1);
      e = c0_tab[i][C0_MSB_FIRST] ? rev(pbyte) : pbyte;
      rd_reg(OFS_RX_BUF, {8'h00, e ^ inv}, 16'hFFFF);
      e = d ^ inv;
      check("partner byte", {8'h00, c0_tab[i][C0_MSB_FIRST] ? rev(e) : e}, {8'h00, got});
      check("clock period", 16'(2 * (i + 4) * pre[i]), per[15:0]);
    end
    check("transmit events", 16'h4, tx_cnt[15:0]);
    // A high clear-to-send holds the frame back until it drops
    wr_reg(OFS_CTRL0, 8'h00);
    cts_n <= 1'b1;
    settle();
    arm(1'b0);
    wr_reg(OFS_TX_BUF, 8'h3C);
    settle();
    check("held start", 16'h4, tx_cnt[15:0]);
    cts_n <= 1'b0;
    wait_rx(rx_cnt + 1);
    rd_reg(OFS_RX_BUF, {8'h00, ~pbyte}, 16'hFFFF);
    // Request-to-send, continuous receive, completion events, then overrun
    wr_reg(OFS_CTRL0, 8'h04);
    wr_reg(OFS_CTRL1, 8'h05);
    wr_reg(OFS_SHARED, 8'h0A);
    arm(1'b0);
    wr_reg(OFS_TX_BUF, 8'($urandom));
    wait_rx(rx_cnt + 1);
    check("data input use", 16'h1, 16'(din_used));
    check("handshake enable", 16'h0, 16'(hs_oe_n));
    rd_reg(OFS_RX_BUF, {8'h00, pbyte}, 16'hFFFF);
    wait_rx(rx_cnt + 1);
    wr_reg(OFS_SHARED, 8'h02);
    wr_reg(OFS_TX_BUF, 8'h5A);
    wait_rx(rx_cnt + 1);
    rd_reg(OFS_RX_BUF, 16'h1000, 16'h1000);
    settle();
    check("transmit events", 16'h8, tx_cnt[15:0]);
    // External clock: the bench makes the transfer clock and the block follows it
    wr_reg(OFS_MODE, 8'h09);
    arm(1'b0);
    wr_reg(OFS_TX_BUF, 8'hA5);
    repeat (8) begin
      repeat (8) @(posedge clock);
      ext_ck <= 1'b0;
      repeat (8) @(posedge clock);
      ext_ck <= 1'b1;
    end
    wait_rx(rx_cnt + 1);
    rd_reg(OFS_RX_BUF, {8'h00, pbyte}, 16'hFFFF);
    check("partner byte", 16'h00A5, {8'h00, got});
    end_sim();
  end
endmodule // sync_serial_channel_test
`default_nettype wire

// *** verif/sync_serial_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_checker
  import sio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Pins and events
  input wire logic serial_data_out_pin_o,
  input wire logic serial_data_out_pin_oe_n,
  input wire logic handshake_pin_o,
  input wire logic handshake_pin_oe_n,
  input wire logic tx_event,
  input wire logic rx_event
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  property p_rdata_idle;
    !rd |=> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside an answer");
  property p_rdata_format;
    rd |=> rdata[15:13] == 3'h0 && rdata[11:8] == 4'h0;
  endproperty
  a_rdata_format: assert property (p_rdata_format) else $error("unused read data bits set");
  property p_baud_readback;
    (wr && addr == OFS_BAUD) ##2 (rd && addr == OFS_BAUD) |=> rdata[7:0] == $past(wdata, 3);
  endproperty
  a_baud_readback: assert property (p_baud_readback) else $error("divider readback differs");
  property p_ctrl0_readback;
    (wr && addr == OFS_CTRL0) ##2 (rd && addr == OFS_CTRL0) |=>
      (rdata[7:0] & C0_WR_MASK) == ($past(wdata, 3) & C0_WR_MASK);
  endproperty
  a_ctrl0_readback: assert property (p_ctrl0_readback) else $error("control zero readback differs");
  // ---------------------------------------------------------------------------
  // Events and pins
  // ---------------------------------------------------------------------------
  property p_tx_pulse;
    tx_event |=> !tx_event;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit event longer than one cycle");
  property p_rx_spacing;
    rx_event |=> !rx_event [*8];
  endproperty
  a_rx_spacing: assert property (p_rx_spacing) else $error("receive events closer than one frame");
  property p_reset_idle;
    $rose(nrst) |-> serial_data_out_pin_o && serial_data_out_pin_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("data out not idle after reset");
  property p_rts_busy;
    rx_event && !handshake_pin_oe_n |-> ##[0:2] handshake_pin_o;
  endproperty
  a_rts_busy: assert property (p_rts_busy) else $error("request line stays ready with byte unread");
endmodule // sync_serial_checker
bind sync_serial_channel sync_serial_checker u_sync_serial_checker (
  .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .serial_data_out_pin_o(serial_data_out_pin_o), .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n),
  .handshake_pin_o(handshake_pin_o), .handshake_pin_oe_n(handshake_pin_oe_n),
  .tx_event(tx_event), .rx_event(rx_event));
`default_nettype wire

// *** verif/sync_serial_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_partner (
  // Link pins
  input wire logic sclk,
  input wire logic sdo,
  output logic sdi,
  // Bench control
  input wire logic pol,
  input wire logic clr,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_bits
);
  logic [3:0] idx = 4'h0;
  initial begin
    sdi = 1'b1;
    rx_bits = 8'h00;
  end
  // Sample on the returning edge, shift on the leaving edge
  always @(sclk or posedge clr) begin
    if (clr) begin
      idx = 4'h0;
    end else if (sclk !== pol) begin
      rx_bits[idx[2:0]] = sdo;
      idx = idx + 4'h1;
      if (idx == 4'h8) begin
        idx = 4'h0;
        sdi = ~sdi; // Line is not held between frames
      end
    end else begin
      sdi = tx_byte[idx[2:0]];
    end
  end
endmodule // sync_serial_partner
`default_nettype wire
